// ### tcc_consts.vh
/*
 Register offsets, field positions and reset values of the 32-bit
 counter/timer core. Assumes a word-addressed byte offset bus of 8 bits.
*/
`ifndef TCC_CONSTS_VH
`define TCC_CONSTS_VH

// Register byte offsets
`define TCC_OFS_IRQ_FLAGS    8'h00
`define TCC_OFS_CTRL         8'h04
`define TCC_OFS_COUNT        8'h08
`define TCC_OFS_PRESCALE     8'h0C
`define TCC_OFS_SOURCE       8'h10
`define TCC_OFS_IRQ_MASK     8'h14
`define TCC_OFS_PRE_COUNT    8'h18

// Interrupt flag layout
`define TCC_NUM_FLAGS        5
`define TCC_FLAG_CAPTURE     4

// Counter control fields
`define TCC_CTRL_ENABLE      0
`define TCC_CTRL_RESET       1

// Count source field
`define TCC_SRC_EXTERNAL     0

// Reset values
`define TCC_RST_WORD         32'h00000000
`define TCC_RST_FLAGS        5'h00
`define TCC_RST_CTRL         2'h0

// Clock rate of the peripheral clock, in kHz
`define TCC_CLK_KHZ          10000

`endif

// ### tcc_edge_sync.v
/*
 Two-flop synchroniser with rising-edge detector for the external count
 input. Assumes the pin is asynchronous to clk_sys and its high and low
 phases each last at least two clk_sys periods.
*/
`timescale 1ns/100ps

module tcc_edge_sync (
    clk_sys,
    rstn,
    pin_in,
    rise_pulse
);
    input  wire clk_sys;
    input  wire rstn;
    input  wire pin_in;
    output reg  rise_pulse;

    reg meta_reg;
    reg sync_reg;
    reg last_reg;

    // First flop feeds only the second; edge taken from the settled stages
    always @(posedge clk_sys) begin
        if (!rstn) begin
            meta_reg   <= 1'b0;
            sync_reg   <= 1'b0;
            last_reg   <= 1'b0;
            rise_pulse <= 1'b0;
        end else begin
            meta_reg   <= pin_in;
            sync_reg   <= meta_reg;
            last_reg   <= sync_reg;
            rise_pulse <= sync_reg & ~last_reg;
        end
    end
endmodule // tcc_edge_sync

// ### tcc_prescaler.v
/*
 Prescale counter: gives one tick pulse every limit+1 accepted count
 events. Assumes count_en is a one-cycle qualifier on the same clock.
*/
`timescale 1ns/100ps

module tcc_prescaler #(
    parameter WIDTH = 32
) (
    clk_sys,
    rstn,
    clear,
    count_en,
    limit,
    pre_count,
    tick
);
    input  wire             clk_sys;
    input  wire             rstn;
    input  wire             clear;
    input  wire             count_en;
    input  wire [WIDTH-1:0] limit;
    output reg  [WIDTH-1:0] pre_count;
    output wire             tick;

    // Tick on the event that arrives while the count is at or above the limit
    assign tick = count_en & ~clear & (pre_count >= limit);

    // Wraps to zero on the tick; a lowered limit below the count wraps on the next count event
    always @(posedge clk_sys) begin
        if (!rstn || clear) begin
            pre_count <= {WIDTH{1'b0}};
        end else if (tick) begin
            pre_count <= {WIDTH{1'b0}};
        end else if (count_en) begin
            pre_count <= pre_count + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end
endmodule // tcc_prescaler

// ### tcc_timer_core.v
/*
 Core of a 32-bit counter/timer: interrupt pending flags with mask and
 interrupt line, counter control, count register and prescaler.
 Register map, byte offsets on an 8-bit address:
   0x00 pending flags, write one to acknowledge
   0x04 counter control, bit 0 enable, bit 1 hold at zero
   0x08 count value, read and write
   0x0C prescale limit
   0x10 count source, bit 0 selects the external pin
   0x14 interrupt mask, same layout as the flags
   0x18 prescale counter, read only
 Unmapped offsets read zero and ignore writes.
 After reset every register reads zero; counting starts only once
 software sets the enable bit.
 Assumes match and capture event pulses come from logic on clk_sys, and
 the external count pin is asynchronous. Read data is registered and
 stands for the one cycle after the read strobe only; the bus never waits.
 A software write to the count register while counting drops that
 cycle's increment, and count_tick stays low for it.
*/
// The plain strobed port was decided locally.
`timescale 1ns/100ps
`include "tcc_consts.vh"

module tcc_timer_core #(
    parameter CNT_WIDTH = 32,
    parameter NUM_MATCH = 4
) (
    clk_sys,
    rstn,
    reg_addr,
    reg_wdata,
    reg_wr,
    reg_rd,
    reg_rdata,
    match_event,
    capture_event,
    ext_count_pin,
    count_value,
    count_tick,
    irq_flags,
    irq
);
    input  wire                 clk_sys;
    input  wire                 rstn;
    input  wire [7:0]           reg_addr;
    input  wire [31:0]          reg_wdata;
    input  wire                 reg_wr;
    input  wire                 reg_rd;
    output reg  [31:0]          reg_rdata;
    input  wire [NUM_MATCH-1:0] match_event;
    input  wire                 capture_event;
    input  wire                 ext_count_pin;
    output reg  [CNT_WIDTH-1:0] count_value;
    output reg                  count_tick;
    output reg  [`TCC_NUM_FLAGS-1:0] irq_flags;
    output reg                  irq;

    // Register state
    reg  [`TCC_NUM_FLAGS-1:0] flags_reg;
    reg  [`TCC_NUM_FLAGS-1:0] flags_next;
    reg  [`TCC_NUM_FLAGS-1:0] mask_reg;
    reg  [`TCC_NUM_FLAGS-1:0] mask_next;
    reg  [1:0]                ctrl_reg;
    reg  [1:0]                ctrl_next;
    reg                       source_reg;
    reg                       source_next;
    reg  [CNT_WIDTH-1:0]      prescale_reg;
    reg  [CNT_WIDTH-1:0]      prescale_next;
    reg  [CNT_WIDTH-1:0]      count_reg;
    reg  [CNT_WIDTH-1:0]      count_next;
    reg  [31:0]               rdata_next;

    wire [CNT_WIDTH-1:0]      pre_count;
    wire                      pre_tick;
    wire                      ext_rise;
    wire                      count_en;
    wire                      ctr_enable;
    wire                      ctr_reset;
    wire [`TCC_NUM_FLAGS-1:0] flag_set;

    // Write strobes per register
    wire                      wr_flags;
    wire                      wr_ctrl;
    wire                      wr_count;
    wire                      wr_prescale;
    wire                      wr_source;
    wire                      wr_mask;

    // Next values of the flopped outputs
    reg                       tick_next;
    reg                       irq_next;

    // Address compare, shared by every write decode
    function wr_hit;
        input [7:0] addr;
        input [7:0] ofs;
        input       wr;
        begin
            wr_hit = wr & (addr == ofs);
        end
    endfunction

    // Widen a narrow field into a read word, upper bits zero
    function [31:0] zext5;
        input [`TCC_NUM_FLAGS-1:0] val;
        begin
            zext5 = {{(32-`TCC_NUM_FLAGS){1'b0}}, val};
        end
    endfunction

    assign ctr_enable = ctrl_reg[`TCC_CTRL_ENABLE];
    assign ctr_reset  = ctrl_reg[`TCC_CTRL_RESET];

    // One decode per register, shared by next-state and output logic
    assign wr_flags    = wr_hit(reg_addr, `TCC_OFS_IRQ_FLAGS, reg_wr);
    assign wr_ctrl     = wr_hit(reg_addr, `TCC_OFS_CTRL, reg_wr);
    assign wr_count    = wr_hit(reg_addr, `TCC_OFS_COUNT, reg_wr);
    assign wr_prescale = wr_hit(reg_addr, `TCC_OFS_PRESCALE, reg_wr);
    assign wr_source   = wr_hit(reg_addr, `TCC_OFS_SOURCE, reg_wr);
    assign wr_mask     = wr_hit(reg_addr, `TCC_OFS_IRQ_MASK, reg_wr);

    // Source code that selects the external pin
    localparam SRC_PIN = 1'h1;

    // Events: match channels in low bits, capture on top
    assign flag_set = {capture_event, match_event};

    // External pin edges or every peripheral clock cycle
    // Pin pulses shorter than two clk_sys periods may be missed
    assign count_en = ctr_enable &
                      ((source_reg == SRC_PIN) ? ext_rise : 1'b1);

    tcc_edge_sync u_ext_sync (
        .clk_sys    (clk_sys),
        .rstn       (rstn),
        .pin_in     (ext_count_pin),
        .rise_pulse (ext_rise)
    );

    // Prescaler held at zero while the counter reset bit is set
    tcc_prescaler #(
        .WIDTH (CNT_WIDTH)
    ) u_prescaler (
        .clk_sys   (clk_sys),
        .rstn      (rstn),
        .clear     (ctr_reset),
        .count_en  (count_en),
        .limit     (prescale_reg),
        .pre_count (pre_count),
        .tick      (pre_tick)
    );

    // Pending flags: new events win over a write-one acknowledge
    // Only the low five write bits matter; upper bits are dropped
    always @* begin
        flags_next = flags_reg;
        if (wr_flags) begin
            flags_next = flags_reg & ~reg_wdata[`TCC_NUM_FLAGS-1:0];
        end
        flags_next = flags_next | flag_set;
    end

    // Interrupt mask, same layout as the flags
    always @* begin
        mask_next = mask_reg;
        if (wr_mask) begin
            mask_next = reg_wdata[`TCC_NUM_FLAGS-1:0];
        end
    end

    // Counter control: enable and hold-at-zero bits
    always @* begin
        ctrl_next = ctrl_reg;
        if (wr_ctrl) begin
            ctrl_next = reg_wdata[1:0];
        end
    end

    // Count source select
    always @* begin
        source_next = source_reg;
        if (wr_source) begin
            source_next = reg_wdata[`TCC_SRC_EXTERNAL];
        end
    end

    // Prescale limit; a new limit applies from the next count event
    always @* begin
        prescale_next = prescale_reg;
        if (wr_prescale) begin
            prescale_next = reg_wdata[CNT_WIDTH-1:0];
        end
    end

    // Count: reset bit over software write over prescaled increment
    // A write while counting drops that step; the prescaler runs on
    always @* begin
        count_next = count_reg;
        if (ctr_reset) begin
            count_next = {CNT_WIDTH{1'b0}};
        end else if (wr_count) begin
            count_next = reg_wdata[CNT_WIDTH-1:0];
        end else if (pre_tick) begin
            count_next = count_reg + {{(CNT_WIDTH-1){1'b0}}, 1'b1};
        end
    end

    // Read mux; unmapped offsets read zero and writes there do nothing
    always @* begin
        rdata_next = 32'h00000000;
        if (reg_rd) begin
            case (reg_addr)
                `TCC_OFS_IRQ_FLAGS: rdata_next = zext5(flags_reg);
                `TCC_OFS_CTRL:      rdata_next = {30'h00000000, ctrl_reg};
                `TCC_OFS_COUNT:     rdata_next = count_reg;
                `TCC_OFS_PRESCALE:  rdata_next = prescale_reg;
                `TCC_OFS_SOURCE:    rdata_next = {31'h00000000, source_reg};
                `TCC_OFS_IRQ_MASK:  rdata_next = zext5(mask_reg);
                `TCC_OFS_PRE_COUNT: rdata_next = pre_count;
                default:            rdata_next = 32'h00000000;
            endcase
        end
    end

    // Tick only when the count really steps; a write or hold wins
    always @* begin
        tick_next = pre_tick & ~ctr_reset & ~wr_count;
        irq_next  = |(flags_next & mask_next);
    end

    // Flags and mask; reset clears every pending source
    always @(posedge clk_sys) begin
        if (!rstn) begin
            flags_reg <= `TCC_RST_FLAGS;
            mask_reg  <= `TCC_RST_FLAGS;
        end else begin
            flags_reg <= flags_next;
            mask_reg  <= mask_next;
        end
    end

    // Control and source; counting is off after reset
    always @(posedge clk_sys) begin
        if (!rstn) begin
            ctrl_reg   <= `TCC_RST_CTRL;
            source_reg <= 1'b0;
        end else begin
            ctrl_reg   <= ctrl_next;
            source_reg <= source_next;
        end
    end

    // Prescale limit
    always @(posedge clk_sys) begin
        if (!rstn) begin
            prescale_reg <= `TCC_RST_WORD;
        end else begin
            prescale_reg <= prescale_next;
        end
    end

    // Count register
    always @(posedge clk_sys) begin
        if (!rstn) begin
            count_reg <= `TCC_RST_WORD;
        end else begin
            count_reg <= count_next;
        end
    end

    // Read data, zero outside the slot after a read strobe
    always @(posedge clk_sys) begin
        if (!rstn) begin
            reg_rdata <= 32'h00000000;
        end else begin
            reg_rdata <= rdata_next;
        end
    end

    // Count mirror and tick, both from the next state so they line up
    always @(posedge clk_sys) begin
        if (!rstn) begin
            count_value <= `TCC_RST_WORD;
            count_tick  <= 1'b0;
        end else begin
            count_value <= count_next;
            count_tick  <= tick_next;
        end
    end

    // Flag mirror and level line; next values avoid a cycle of lag
    always @(posedge clk_sys) begin
        if (!rstn) begin
            irq_flags <= `TCC_RST_FLAGS;
            irq       <= 1'b0;
        end else begin
            irq_flags <= flags_next;
            irq       <= irq_next;
        end
    end
endmodule // tcc_timer_core

// ### tccr_chk.sv
/*
 Port checker of the counter/timer core.
 Assumes one clock, clk_sys, and a synchronous active-low rstn.
*/
`timescale 1ns/100ps
module tccr_chk (
    input wire        clk_sys,
    input wire        rstn,
    input wire [7:0]  reg_addr,
    input wire [31:0] reg_wdata,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [31:0] reg_rdata,
    input wire [3:0]  match_event,
    input wire        capture_event,
    input wire [31:0] count_value,
    input wire        count_tick,
    input wire [4:0]  irq_flags,
    input wire        irq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // Acknowledge write on flag zero
    wire clr0 = reg_wr && reg_addr == 8'h00 && reg_wdata[0];
    wire ctl  = reg_wr && reg_addr == 8'h04;

    property p_set; match_event[0] |=> irq_flags[0]; endproperty
    a_set: assert property (p_set) else $error("match flag not set");
    property p_cap; capture_event |=> irq_flags[4]; endproperty
    a_cap: assert property (p_cap) else $error("capture flag not set");
    property p_w1c; clr0 && !match_event[0] |=> !irq_flags[0]; endproperty
    a_w1c: assert property (p_w1c) else $error("flag not cleared");
    property p_keep; irq_flags[0] && !clr0 |=> irq_flags[0]; endproperty
    a_keep: assert property (p_keep) else $error("flag lost");
    property p_rdz; !reg_rd |=> reg_rdata == 32'h0; endproperty
    a_rdz: assert property (p_rdz) else $error("read data outside slot");
    property p_rdf;
        reg_rd && reg_addr == 8'h00 |=> reg_rdata == {27'h0, $past(irq_flags)};
    endproperty
    a_rdf: assert property (p_rdf) else $error("flag read wrong");
    property p_tick; count_tick |-> count_value == $past(count_value) + 32'h1; endproperty
    a_tick: assert property (p_tick) else $error("count step wrong");
    property p_crst; ctl && reg_wdata[1] |=> ##1 count_value == 32'h0; endproperty
    a_crst: assert property (p_crst) else $error("count not held at zero");
    property p_stop;
        ctl && reg_wdata[1:0] == 2'h0 |=> ##2 (!count_tick && $stable(count_value)) [*3];
    endproperty
    a_stop: assert property (p_stop) else $error("count moved while stopped");
    property p_irq; irq |-> irq_flags != 5'h00; endproperty
    a_irq: assert property (p_irq) else $error("irq without flag");

    // Main scenarios reached
    c_tick: cover property (count_tick);
    c_irq: cover property (irq);
    c_race: cover property (clr0 && match_event[0]);
endmodule // tccr_chk

bind tcc_timer_core tccr_chk u_chk (
    .clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .match_event(match_event), .capture_event(capture_event),
    .count_value(count_value), .count_tick(count_tick), .irq_flags(irq_flags), .irq(irq)
);

// ### test_timer32_core_control_regs.sv
/*
 Self-checking bench of the counter/timer core.
 Assumes the 8-bit register map of the core and a 100 ns clock.
*/
`timescale 1ns/100ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_fail++; \
    $display("wrong value t=%0t got=%h exp=%h", $time, a, b); end end
module test_timer32_core_control_regs;
    reg         clk_sys = 1'b0;
    reg         rstn = 1'b0;
    reg  [7:0]  reg_addr = 8'h00;
    reg  [31:0] reg_wdata = 32'h0;
    reg         reg_wr = 1'b0;
    reg         reg_rd = 1'b0;
    reg  [3:0]  match_event = 4'h0;
    reg         capture_event = 1'b0;
    reg         ext_count_pin = 1'b0;
    wire [31:0] reg_rdata, count_value;
    wire        count_tick, irq;
    wire [4:0]  irq_flags;
    integer     seed = 32'h4FA762A3;
    integer     n_fail = 0, checks_done = 0, i, n, p;
    reg  [4:0]  expf = 5'h00;
    reg  [31:0] v;

    always #50 clk_sys = ~clk_sys;

    tcc_timer_core dut (
        .clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .match_event(match_event), .capture_event(capture_event),
        .ext_count_pin(ext_count_pin), .count_value(count_value),
        .count_tick(count_tick), .irq_flags(irq_flags), .irq(irq)
    );

    task complete_run;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // One-cycle bus write
    task wr(input [7:0] a, input [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    // Read; data only valid in the following cycle
    task rd(input [7:0] a, input [31:0] e);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 `CHK(reg_rdata, e)
    endtask

    // Event pulse, flags expected one cycle later
    task ev(input [3:0] m, input c);
        @(posedge clk_sys);
        match_event <= m;
        capture_event <= c;
        @(posedge clk_sys);
        match_event <= 4'h0;
        capture_event <= 1'b0;
        expf = expf | {c, m};
        #1 `CHK(irq_flags, expf)
    endtask

    // Cycles up to the next count tick, bounded
    task to_tick;
        n = 0;
        do begin
            @(posedge clk_sys);
            #1 n++;
        end while (count_tick !== 1'b1 && n < 20);
    endtask

    initial begin
        repeat (12) @(posedge clk_sys);
        rstn <= 1'b1;
        // Only defined offsets are written; reserved ones are only read
        wr(8'h00, 32'hFFFFFFFF);
        rd(8'h1C, 32'h0);
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h0);
        rd(8'h08, 32'h0);
        wr(8'h14, 32'h1F);
        for (i = 0; i < 20; i++) begin
            v = $random(seed);
            ev(v[3:0], v[4]);
            `CHK(irq, |expf)
            v = $random(seed);
            wr(8'h00, v);
            expf = expf & ~v[4:0];
            rd(8'h00, {27'h0, expf});
        end
        // Set and clear on the same edge: set wins
        ev(4'hF, 1'b1);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= 8'h00;
        reg_wdata <= 32'h1F;
        match_event <= 4'h2;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        match_event <= 4'h0;
        #1 `CHK(irq_flags, 5'h02)
        wr(8'h14, 32'h0);
        @(posedge clk_sys);
        #1 `CHK(irq, 1'b0)
        v = $random(seed);
        wr(8'h08, v);
        rd(8'h08, v);
        wr(8'h04, 32'h3);
        rd(8'h08, 32'h0);
        // Tick spacing for several prescale limits, zero included
        for (i = 0; i < 5; i++) begin
            p = (i == 0) ? 0 : ($random(seed) & 7);
            wr(8'h0C, p);
            wr(8'h04, 32'h1);
            to_tick;
            to_tick;
            `CHK(n, p + 1)
            wr(8'h04, 32'h0);
        end
        // Five pin pulses counted from the external source
        wr(8'h04, 32'h2);
        wr(8'h10, 32'h1);
        wr(8'h0C, 32'h0);
        wr(8'h04, 32'h1);
        for (i = 0; i < 5; i++) begin
            repeat (3) @(posedge clk_sys);
            ext_count_pin <= 1'b1;
            repeat (3) @(posedge clk_sys);
            ext_count_pin <= 1'b0;
        end
        repeat (6) @(posedge clk_sys);
        wr(8'h04, 32'h0);
        rd(8'h08, 32'h5);
        complete_run;
    end

    // Hang guard, far beyond the few hundred cycles needed
    initial begin
        #3000000;
        n_fail++;
        complete_run;
    end
endmodule // test_timer32_core_control_regs
